// ### core/ufe_fall_enable.sv
/*
  ufe_fall_enable: falling-edge event enable register with set and clear
  aliases, and the falling-edge detectors that those enables gate.
  assumes all inputs are synchronous to clk_sys and reads/writes are single-cycle
  strobes from the register port of the transceiver.
*/
// What this block does
// R1: id ground fall raises event when enabled
// R2: id fall masked pullup off and 50ms after
// R3: session end fall raises event when enabled
// R4: session valid fall raises event when enabled
// R5: vbus ok fall raises event when enabled
// R6: host disconnect fall raises event when enabled
// R7: host disconnect event only in host mode
// R8: enables reset to one, reserved bits zero
// R9: set alias sets ones, reads enable register
// R10: clear alias clears ones, reads enable register
// R11: zeros written to clear alias change nothing
// R12: read-cycle event goes in read data, not latched
// R13: reserved bits ignore writes, read zero
`timescale 1ns/100ps
module ufe_fall_enable #(
  parameter int ID_SETTLE_CYC = ufe_pkg::UFE_ID_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              reset_n,
  // register port
  input  wire ufe_pkg::ufe_reg_req_t             reg_req,
  output logic [ufe_pkg::UFE_DATA_W-1:0]         reg_rdata,
  output logic                                   reg_rvalid,
  // line state and mode controls
  input  wire ufe_pkg::ufe_line_t                line_in,
  input  wire logic                              id_pin_pullup_on,
  input  wire logic                              dplus_pulldown_on,
  input  wire logic                              dminus_pulldown_on,
  // latch register read strobe, from the latch register decode
  input  wire logic                              latch_read,
  // events
  output logic [ufe_pkg::UFE_NUM_EVT-1:0]        fall_event,
  output logic [ufe_pkg::UFE_NUM_EVT-1:0]        fall_latch,
  output logic [ufe_pkg::UFE_NUM_EVT-1:0]        fall_enable
);
  import ufe_pkg::*;

  localparam int CNT_W = $clog2(ID_SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(ID_SETTLE_CYC);

  logic [UFE_NUM_EVT-1:0] enable_q;
  logic [UFE_NUM_EVT-1:0] line_q;
  logic [UFE_NUM_EVT-1:0] fall_now;
  logic [CNT_W-1:0]       settle_q;
  logic                   id_masked;
  logic                   host_mode;
  logic                   hit_en;
  logic                   hit_set;
  logic                   hit_clr;
  logic [UFE_NUM_EVT-1:0] wbits;

  assign hit_en    = reg_req.addr == UFE_OFS_ENABLE;
  assign hit_set   = reg_req.addr == UFE_OFS_ENABLE_SET;
  assign hit_clr   = reg_req.addr == UFE_OFS_ENABLE_CLR;
  assign wbits     = reg_req.wdata[UFE_NUM_EVT-1:0]; // R13
  assign host_mode = dplus_pulldown_on & dminus_pulldown_on;
  assign id_masked = !id_pin_pullup_on || (settle_q != SETTLE_LAST);

  // enable register, one storage behind three addresses
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      enable_q <= UFE_ENABLE_RESET; // R8
    end else if (reg_req.wr) begin
      if (hit_en)
        enable_q <= wbits;
      else if (hit_set)
        enable_q <= enable_q | wbits; // R9
      else if (hit_clr)
        enable_q <= enable_q & ~wbits; // R10 R11
    end
  end

  // settle counter runs from pull-up on, saturates at the settle count
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !id_pin_pullup_on)
      settle_q <= '0; // R2
    else if (settle_q != SETTLE_LAST)
      settle_q <= settle_q + CNT_W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      line_q <= '0;
    else
      line_q <= line_in;
  end

  always_comb begin
    fall_now = line_q & ~line_in & enable_q; // R1 R3 R4 R5 R6
    if (id_masked)
      fall_now[UFE_BIT_ID_GND] = 1'b0; // R2
    if (!host_mode)
      fall_now[UFE_BIT_HOST_DISC] = 1'b0; // R7
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      fall_event <= '0;
    else
      fall_event <= fall_now;
  end

  // latch: an event in the latch read cycle goes to the read data instead,
  // events during reads of other registers are still kept
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      fall_latch <= '0;
    else if (latch_read && reg_req.rd)
      fall_latch <= '0; // R12
    else
      fall_latch <= fall_latch | fall_now;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd & (hit_en | hit_set | hit_clr);
      if (reg_req.rd && (hit_en || hit_set || hit_clr))
        reg_rdata <= {3'h0, enable_q}; // R9 R10 R13
      else if (reg_req.rd && latch_read)
        reg_rdata <= {3'h0, fall_latch | fall_now}; // R12
      else
        reg_rdata <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      fall_enable <= UFE_ENABLE_RESET;
    else
      fall_enable <= enable_q;
  end

  // assertions
  property p_reset_val;
    @(posedge clk_sys) $rose(reset_n) |-> enable_q == UFE_ENABLE_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("enable reset value wrong"); // R8

  property p_set;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.wr && hit_set |=> enable_q == ($past(enable_q) | $past(wbits));
  endproperty
  a_set: assert property (p_set) else $error("set alias wrong"); // R9

  property p_clr;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.wr && hit_clr |=> enable_q == ($past(enable_q) & ~$past(wbits));
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias wrong"); // R10

  property p_clr_zero;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.wr && hit_clr && wbits == '0 |=> $stable(enable_q);
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear zero changed bits"); // R11

  property p_rsvd;
    @(posedge clk_sys) disable iff (!reset_n) (reg_rdata & UFE_RSVD_MASK) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero"); // R13

  property p_vbus;
    @(posedge clk_sys) disable iff (!reset_n)
      line_q[UFE_BIT_VBUS_OK] && !line_in.vbus_ok_level && enable_q[UFE_BIT_VBUS_OK]
      |=> fall_event[UFE_BIT_VBUS_OK];
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus fall missed"); // R5

  property p_id_mask;
    @(posedge clk_sys) disable iff (!reset_n)
      !id_pin_pullup_on |=> !fall_event[UFE_BIT_ID_GND];
  endproperty
  a_id_mask: assert property (p_id_mask) else $error("id event not masked"); // R2

  property p_host;
    @(posedge clk_sys) disable iff (!reset_n)
      !host_mode |=> !fall_event[UFE_BIT_HOST_DISC];
  endproperty
  a_host: assert property (p_host) else $error("host event outside host mode"); // R7

  property p_read_rd;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.rd && hit_en |=> reg_rvalid && reg_rdata == {3'h0, $past(enable_q)};
  endproperty
  a_read_rd: assert property (p_read_rd) else $error("read data wrong"); // R13

  property p_id_fall;
    @(posedge clk_sys) disable iff (!reset_n)
      line_q[UFE_BIT_ID_GND] && !line_in.id_pin_grounded && enable_q[UFE_BIT_ID_GND]
      && !id_masked |=> fall_event[UFE_BIT_ID_GND];
  endproperty
  a_id_fall: assert property (p_id_fall) else $error("id ground fall missed"); // R1

  property p_id_settle;
    @(posedge clk_sys) disable iff (!reset_n)
      id_pin_pullup_on && (settle_q != SETTLE_LAST) |=> !fall_event[UFE_BIT_ID_GND];
  endproperty
  a_id_settle: assert property (p_id_settle) else $error("id event inside settle time"); // R2

  property p_sess_end;
    @(posedge clk_sys) disable iff (!reset_n)
      line_q[UFE_BIT_SESS_END] && !line_in.session_end_level && enable_q[UFE_BIT_SESS_END]
      |=> fall_event[UFE_BIT_SESS_END];
  endproperty
  a_sess_end: assert property (p_sess_end) else $error("session end fall missed"); // R3

  property p_sess_valid;
    @(posedge clk_sys) disable iff (!reset_n)
      line_q[UFE_BIT_SESS_VALID] && !line_in.session_valid_level
      && enable_q[UFE_BIT_SESS_VALID] |=> fall_event[UFE_BIT_SESS_VALID];
  endproperty
  a_sess_valid: assert property (p_sess_valid) else $error("session valid fall missed"); // R4

  property p_host_fall;
    @(posedge clk_sys) disable iff (!reset_n)
      line_q[UFE_BIT_HOST_DISC] && !line_in.host_disconnect_level
      && enable_q[UFE_BIT_HOST_DISC] && host_mode |=> fall_event[UFE_BIT_HOST_DISC];
  endproperty
  a_host_fall: assert property (p_host_fall) else $error("host disconnect fall missed"); // R6

  property p_latch_rd;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.rd && latch_read |=> fall_latch == '0;
  endproperty
  a_latch_rd: assert property (p_latch_rd) else $error("event latched in read cycle"); // R12

  property p_rd_event;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.rd && latch_read && !(hit_en || hit_set || hit_clr)
      |=> reg_rdata[UFE_NUM_EVT-1:0] == ($past(fall_latch) | $past(fall_now));
  endproperty
  a_rd_event: assert property (p_rd_event) else $error("read cycle event not reported"); // R12

  c_set:  cover property (@(posedge clk_sys) reg_req.wr && hit_set);
  c_clr:  cover property (@(posedge clk_sys) reg_req.wr && hit_clr);
  c_id:   cover property (@(posedge clk_sys) fall_event[UFE_BIT_ID_GND]);
  c_latch: cover property (@(posedge clk_sys) reg_req.rd && latch_read && (fall_now != '0));
endmodule // ufe_fall_enable

// ### core/ufe_pkg.sv
/*
  ufe_pkg: offsets, field positions, reset values, timing and carrier types
  for the falling-edge event enable register block.
  assumes a 200 MHz system clock and an 8-bit register port with 6-bit addresses.
*/
package ufe_pkg;
  localparam int         UFE_ADDR_W         = 6;
  localparam int         UFE_DATA_W         = 8;
  localparam int         UFE_NUM_EVT        = 5;
  localparam logic [5:0] UFE_OFS_ENABLE     = 6'h10;
  localparam logic [5:0] UFE_OFS_ENABLE_SET = 6'h11;
  localparam logic [5:0] UFE_OFS_ENABLE_CLR = 6'h12;
  // field positions inside the enable byte
  localparam int         UFE_BIT_HOST_DISC  = 0;
  localparam int         UFE_BIT_VBUS_OK    = 1;
  localparam int         UFE_BIT_SESS_VALID = 2;
  localparam int         UFE_BIT_SESS_END   = 3;
  localparam int         UFE_BIT_ID_GND     = 4;
  localparam logic [4:0] UFE_ENABLE_RESET   = 5'h1F;
  localparam logic [7:0] UFE_RSVD_MASK      = 8'hE0;
  // id pull-up settling time
  localparam int         UFE_CLK_MHZ        = 200;
  localparam int         UFE_ID_SETTLE_MS   = 50;
  localparam int         UFE_ID_SETTLE_CYC  = UFE_ID_SETTLE_MS * 1000 * UFE_CLK_MHZ;

  typedef struct packed {
    logic id_pin_grounded;
    logic session_end_level;
    logic session_valid_level;
    logic vbus_ok_level;
    logic host_disconnect_level;
  } ufe_line_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [UFE_ADDR_W-1:0] addr;
    logic [UFE_DATA_W-1:0] wdata;
  } ufe_reg_req_t;
endpackage

// ### tb/ufe_link_model.sv
/*
  ufe_link_model: link controller side of the register port.
  assumes single-cycle strobes taken on the rising edge of clk_sys.
*/
`timescale 1ns/100ps
module ufe_link_model
  import ufe_pkg::*;
(
  // clock
  input  wire logic           clk_sys,
  // register port
  output ufe_pkg::ufe_reg_req_t reg_req
);
  initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 6'h00, wdata: 8'h00};

  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    // released lines flip so a stale value cannot pass for a live one
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
  endtask
endmodule // ufe_link_model

// ### tb/usb_fall_event_enable_regs_tb.sv
/*
  usb_fall_event_enable_regs_tb: self-checking bench for ufe_fall_enable.
  assumes the link model drives the register port; settle time shortened to 20.
*/
`timescale 1ns/100ps
module usb_fall_event_enable_regs_tb;
  import ufe_pkg::*;
  logic         clk_sys = 1'b0;
  logic         reset_n = 1'b0;
  ufe_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         reg_rvalid;
  ufe_line_t    line_in = '1;
  logic         pu = 1'b1;
  logic         dp = 1'b1;
  logic         dm = 1'b1;
  logic [4:0]   fall_event;
  logic [4:0]   fall_enable;
  logic [4:0]   fall_latch;
  logic         latch_rd;
  int           bad_count = 0;
  int           check_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  ufe_link_model LINK (.clk_sys(clk_sys), .reg_req(reg_req));
  // latch register decode stands outside the block
  assign latch_rd = reg_req.rd && (reg_req.addr == 6'h14);
  ufe_fall_enable #(.ID_SETTLE_CYC(20)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .line_in(line_in),
    .id_pin_pullup_on(pu), .dplus_pulldown_on(dp), .dminus_pulldown_on(dm),
    .latch_read(latch_rd), .fall_event(fall_event), .fall_latch(fall_latch),
    .fall_enable(fall_enable));

  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    LINK.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [8:0] e);
    LINK.access(1'b0, a, 8'h00);
    chk({reg_rvalid, reg_rdata}, e);
  endtask

  // every line high, then all fall together; pulse stands one edge after the fall
  task automatic fall(input logic [4:0] e);
    @(posedge clk_sys) line_in <= '1;
    repeat (2) @(posedge clk_sys);
    line_in <= '0;
    @(posedge clk_sys);
    #1 chk({4'h0, fall_event}, {4'h0, e});
  endtask

  task automatic t_reset;
    rd(6'h10, 9'h11F);
    rd(6'h11, 9'h11F);
    rd(6'h12, 9'h11F);
    chk({4'h0, fall_enable}, 9'h01F);
    $display("done reset");
  endtask

  task automatic t_alias;
    wr(6'h12, 8'hE1);
    rd(6'h10, 9'h11E);
    chk({4'h0, fall_enable}, 9'h01E);
    wr(6'h11, 8'hE1);
    rd(6'h11, 9'h11F);
    wr(6'h10, 8'hE5);
    rd(6'h12, 9'h105);
    rd(6'h20, 9'h000);
    wr(6'h11, 8'hFF);
    rd(6'h10, 9'h11F);
    wr(6'h12, 8'hE0);
    rd(6'h10, 9'h11F);
    $display("done alias");
  endtask

  task automatic t_event;
    fall(5'h1F);
    wr(6'h12, 8'h04);
    fall(5'h1B);
    wr(6'h12, 8'h0A);
    fall(5'h11);
    wr(6'h11, 8'h0E);
    dm <= 1'b0;
    fall(5'h1E);
    pu <= 1'b0;
    fall(5'h0E);
    pu <= 1'b1;
    fall(5'h0E);
    repeat (30) @(posedge clk_sys);
    fall(5'h1E);
    $display("done event");
  endtask

  // an event in the latch read cycle shows in the read data, not the latch
  task automatic t_latch;
    rd(6'h14, 9'h01F);
    chk({4'h0, fall_latch}, 9'h000);
    @(posedge clk_sys) line_in <= '1;
    fork
      rd(6'h14, 9'h01E);
      @(posedge clk_sys) line_in <= '0;
    join
    chk({4'h0, fall_latch}, 9'h000);
    fall(5'h1E);
    chk({4'h0, fall_latch}, 9'h01E);
    $display("done latch");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_alias();
    t_event();
    t_latch();
    finish_test();
  end

  initial begin
    #5000;
    bad_count++;
    finish_test();
  end
endmodule // usb_fall_event_enable_regs_tb
